// [hbf_fault_if.sv]
`default_nettype none
// =============================================================
// Synchronised fault detector levels
// =============================================================
interface hbf_fault_if #(
    parameter int N = 6
);
    logic [N-1:0] oc;
    logic [N-1:0] underload_flag;
    logic [N-1:0] tsd;
    logic [N-1:0] tw;
    logic         ov;
    logic         uv;
    logic         en;
    modport src (output oc, underload_flag, tsd, tw, ov, uv, en);
    modport dst (input  oc, underload_flag, tsd, tw, ov, uv, en);
endinterface
`default_nettype wire

// [hbf_host.sv]
`default_nettype none
module hbf_host
    import hbf_pkg::*;
(
    // Clock and answer
    input  wire logic        clk,
    input  wire logic        pready,
    // Request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // =========================================================
    // One transfer, held until the answer is sampled
    // =========================================================
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Clear the fault memory first, then reprogram the bridges
    task rearm(input logic [31:0] c);
        apb(ADDR_CTRL, 1'b1, 32'h8000_0000 | (c & 32'hffff_ffc0));
        apb(ADDR_CTRL, 1'b1, c);
    endtask
endmodule
`default_nettype wire

// [hbf_irq.sv]
`default_nettype none
// =============================================================
// Sticky event status, mask and interrupt line
// =============================================================
module hbf_irq
    import hbf_pkg::*;
#(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Events and register writes
    input  wire logic [W-1:0] event_set,
    input  wire logic         wr_stat,
    input  wire logic         wr_mask,
    input  wire logic [W-1:0] wdata,
    // State
    output logic      [W-1:0] stat,
    output logic      [W-1:0] mask,
    output logic              irq
);
    if (W < 1 || W > 32) begin : g_bad_w
        $error("W out of range");
    end

    logic [W-1:0] stat_r;
    logic [W-1:0] mask_r;
    logic         irq_r;
    logic [W-1:0] stat_nxt;
    logic [W-1:0] mask_nxt;
    logic         irq_nxt;

    // Write one clears, a new event in the same cycle wins
    always_comb begin
        stat_nxt = (stat_r & ~(wr_stat ? wdata : '0)) | event_set;
        mask_nxt = wr_mask ? wdata : mask_r;
        irq_nxt  = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat_r <= '0;
            mask_r <= MASK_RST[W-1:0];
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign stat = stat_r;
    assign mask = mask_r;
    assign irq  = irq_r;
endmodule
`default_nettype wire

// [hbf_pkg.sv]
`default_nettype none
// =============================================================
// Constants shared by the half-bridge fault handler
// =============================================================
package hbf_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT  = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h00c;
    localparam logic [11:0] ADDR_CAUSE     = 12'h010;
    // Control word fields
    localparam int CTRL_EN_LSB     = 0;
    localparam int CTRL_CFG_LSB    = 8;
    localparam int CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT  = 16;
    localparam int CTRL_OVERVOLTAGE_LOCKOUT_CTRL_BIT   = 17;
    localparam int CTRL_SRR_BIT    = 31;
    // Status word fields
    localparam int ST_TW_BIT       = 0;
    localparam int ST_OCS_BIT      = 1;
    localparam int ST_ULD_BIT      = 2;
    localparam int ST_TSD_BIT      = 3;
    localparam int ST_PSF_BIT      = 14;
    localparam int ST_LOCK_BIT     = 15;
    localparam int ST_LOFF_LSB     = 16;
    localparam int ST_DRV_LSB      = 24;
    // Cause word fields
    localparam int CS_OC_LSB       = 0;
    localparam int CS_ULD_LSB      = 8;
    localparam int CS_TSD_LSB      = 16;
    // Interrupt event bits
    localparam int EV_TW           = 0;
    localparam int EV_OCS          = 1;
    localparam int EV_ULD          = 2;
    localparam int EV_TSD          = 3;
    localparam int EV_PSF          = 4;
    localparam int EV_NUM          = 5;
    // Reset values and limits
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    localparam int          HB_MAX    = 8;
    localparam int          HB_DFLT   = 6;
endpackage
`default_nettype wire

// [hbf_sync.sv]
`default_nettype none
// =============================================================
// Two-stage synchroniser for all detector pins
// =============================================================
module hbf_sync
    import hbf_pkg::*;
#(
    parameter int N = 6
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Raw pins
    input  wire logic [N-1:0] oc_raw,
    input  wire logic [N-1:0] uld_raw,
    input  wire logic [N-1:0] tsd_raw,
    input  wire logic [N-1:0] tw_raw,
    input  wire logic         ov_raw,
    input  wire logic         uv_raw,
    input  wire logic         en_raw,
    // Synchronised levels
    hbf_fault_if.src          flt
);
    if (N < 1 || N > HB_MAX) begin : g_bad_n
        $error("N out of range");
    end

    localparam int W = 4 * N + 3;

    logic [W-1:0] st1_r;
    logic [W-1:0] st2_r;
    logic [W-1:0] st1_nxt;
    logic [W-1:0] st2_nxt;

    always_comb begin
        st1_nxt = {oc_raw, uld_raw, tsd_raw, tw_raw, ov_raw, uv_raw, en_raw};
        st2_nxt = st1_r;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st1_r <= '0;
            st2_r <= '0;
        end else begin
            st1_r <= st1_nxt;
            st2_r <= st2_nxt;
        end
    end

    assign {flt.oc, flt.underload_flag, flt.tsd, flt.tw, flt.ov, flt.uv, flt.en} = st2_r;
endmodule
`default_nettype wire

// [hbf_top.sv]
`default_nettype none
module hbf_top
    import hbf_pkg::*;
#(
    parameter int NUM_HB = HB_DFLT
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              NRST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Fault detector pins
    input  wire logic [NUM_HB-1:0] OC_DET,
    input  wire logic [NUM_HB-1:0] ULD_DET,
    input  wire logic [NUM_HB-1:0] TSD_DET,
    input  wire logic [NUM_HB-1:0] TW_DET,
    input  wire logic              OV_DET,
    input  wire logic              UV_DET,
    input  wire logic              EN_PIN,
    // Driver gate commands
    output logic      [NUM_HB-1:0] DRV_HS,
    output logic      [NUM_HB-1:0] DRV_LS,
    // Interrupt
    output logic                   IRQ
);
    // =============================================================
    // Elaboration check
    // =============================================================
    if (NUM_HB < 1 || NUM_HB > HB_MAX) begin : g_bad_num
        $error("NUM_HB out of range");
    end

    localparam int N = NUM_HB;

    // =============================================================
    // Input synchronisation
    // =============================================================
    hbf_fault_if #(.N(N)) flt ();

    hbf_sync #(.N(N)) u_sync (
        .clk     (CLK),
        .nrst    (NRST),
        .oc_raw  (OC_DET),
        .uld_raw (ULD_DET),
        .tsd_raw (TSD_DET),
        .tw_raw  (TW_DET),
        .ov_raw  (OV_DET),
        .uv_raw  (UV_DET),
        .en_raw  (EN_PIN),
        .flt     (flt.src)
    );

    // =============================================================
    // APB access decode
    // =============================================================
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        acc;
    logic        wr;
    logic        frame;
    logic        status_reset_request;
    logic        wr_irq_stat;
    logic        wr_irq_mask;

    function automatic logic mapped(input logic [11:0] a);
        return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_IRQ_STAT
            || a == ADDR_IRQ_MASK || a == ADDR_CAUSE;
    endfunction

    // A write completes only at the edge where pready is sampled high
    always_comb begin
        acc         = PSEL && PENABLE && pready_r;
        wr          = acc && PWRITE && mapped(PADDR);
        frame       = wr && PADDR == ADDR_CTRL;
        status_reset_request         = frame && PWDATA[CTRL_SRR_BIT];
        wr_irq_stat = wr && PADDR == ADDR_IRQ_STAT;
        wr_irq_mask = wr && PADDR == ADDR_IRQ_MASK;
    end

    // =============================================================
    // Fault and drive state
    // =============================================================
    logic [N-1:0] hb_en_r;
    logic [N-1:0] hb_cfg_r;
    logic         underload_shutdown_ctrl_r;
    logic         overvoltage_lockout_ctrl_r;
    logic [N-1:0] loff_r;
    logic [N-1:0] cause_oc_r;
    logic [N-1:0] cause_uld_r;
    logic [N-1:0] cause_tsd_r;
    logic         ocs_flag_r;
    logic         uld_flag_r;
    logic         tsd_flag_r;
    logic         tw_flag_r;
    logic         psf_flag_r;
    logic         lock_r;
    logic [N-1:0] drv_hs_r;
    logic [N-1:0] drv_ls_r;

    logic [N-1:0] hb_en_nxt;
    logic [N-1:0] hb_cfg_nxt;
    logic         underload_shutdown_ctrl_nxt;
    logic         overvoltage_lockout_ctrl_nxt;
    logic [N-1:0] loff_nxt;
    logic [N-1:0] cause_oc_nxt;
    logic [N-1:0] cause_uld_nxt;
    logic [N-1:0] cause_tsd_nxt;
    logic         ocs_flag_nxt;
    logic         uld_flag_nxt;
    logic         tsd_flag_nxt;
    logic         tw_flag_nxt;
    logic         psf_flag_nxt;
    logic         lock_nxt;
    logic [N-1:0] drv_hs_nxt;
    logic [N-1:0] drv_ls_nxt;
    logic [N-1:0] loff_set;
    logic         clr;
    logic [EV_NUM-1:0] ev;

    always_comb begin
        // Clear by reset request, or while the enable pin is held low
        clr = status_reset_request || !flt.en;

        // Per-bridge latch-off causes; a set beats a clear
        loff_set      = flt.oc | (flt.underload_flag & {N{underload_shutdown_ctrl_r}}) | flt.tsd;
        loff_nxt      = (clr ? '0 : loff_r) | loff_set;
        cause_oc_nxt  = (clr ? '0 : cause_oc_r) | flt.oc;
        cause_uld_nxt = (clr ? '0 : cause_uld_r) | (flt.underload_flag & {N{underload_shutdown_ctrl_r}});
        cause_tsd_nxt = (clr ? '0 : cause_tsd_r) | flt.tsd;

        // Latched flags; thermal clears only once below the shutdown level
        ocs_flag_nxt = (ocs_flag_r && !clr) || |flt.oc;
        uld_flag_nxt = (uld_flag_r && !clr) || |flt.underload_flag;
        tsd_flag_nxt = (tsd_flag_r && !clr) || |flt.tsd;

        // Self-clearing flags follow the detectors
        tw_flag_nxt  = |flt.tw;
        psf_flag_nxt = flt.uv || flt.ov;

        // Configuration; a latched bridge keeps zero until cleared
        hb_en_nxt  = frame ? PWDATA[CTRL_EN_LSB +: N] : hb_en_r;
        hb_cfg_nxt = frame ? PWDATA[CTRL_CFG_LSB +: N] : hb_cfg_r;
        hb_en_nxt  = hb_en_nxt & ~loff_nxt;
        hb_cfg_nxt = hb_cfg_nxt & ~loff_nxt;
        underload_shutdown_ctrl_nxt  = frame ? PWDATA[CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT] : underload_shutdown_ctrl_r;
        overvoltage_lockout_ctrl_nxt   = frame ? PWDATA[CTRL_OVERVOLTAGE_LOCKOUT_CTRL_BIT] : overvoltage_lockout_ctrl_r;

        // Lockout floats every output but leaves the configuration alone
        lock_nxt = flt.uv || (flt.ov && overvoltage_lockout_ctrl_r) || !flt.en;

        // Drive follows stored state once the lockout goes away
        drv_hs_nxt = lock_nxt ? '0 : hb_en_nxt & hb_cfg_nxt;
        drv_ls_nxt = lock_nxt ? '0 : hb_en_nxt & ~hb_cfg_nxt;

        // Interrupt events on rising flags
        ev         = '0;
        ev[EV_TW]  = tw_flag_nxt && !tw_flag_r;
        ev[EV_OCS] = ocs_flag_nxt && !ocs_flag_r;
        ev[EV_ULD] = uld_flag_nxt && !uld_flag_r;
        ev[EV_TSD] = tsd_flag_nxt && !tsd_flag_r;
        ev[EV_PSF] = psf_flag_nxt && !psf_flag_r;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            hb_en_r     <= '0;
            hb_cfg_r    <= '0;
            underload_shutdown_ctrl_r     <= CTRL_RST[CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT];
            overvoltage_lockout_ctrl_r      <= CTRL_RST[CTRL_OVERVOLTAGE_LOCKOUT_CTRL_BIT];
            loff_r      <= '0;
            cause_oc_r  <= '0;
            cause_uld_r <= '0;
            cause_tsd_r <= '0;
            ocs_flag_r  <= 1'b0;
            uld_flag_r  <= 1'b0;
            tsd_flag_r  <= 1'b0;
            tw_flag_r   <= 1'b0;
            psf_flag_r  <= 1'b0;
            lock_r      <= 1'b1;
            drv_hs_r    <= '0;
            drv_ls_r    <= '0;
        end else begin
            hb_en_r     <= hb_en_nxt;
            hb_cfg_r    <= hb_cfg_nxt;
            underload_shutdown_ctrl_r     <= underload_shutdown_ctrl_nxt;
            overvoltage_lockout_ctrl_r      <= overvoltage_lockout_ctrl_nxt;
            loff_r      <= loff_nxt;
            cause_oc_r  <= cause_oc_nxt;
            cause_uld_r <= cause_uld_nxt;
            cause_tsd_r <= cause_tsd_nxt;
            ocs_flag_r  <= ocs_flag_nxt;
            uld_flag_r  <= uld_flag_nxt;
            tsd_flag_r  <= tsd_flag_nxt;
            tw_flag_r   <= tw_flag_nxt;
            psf_flag_r  <= psf_flag_nxt;
            lock_r      <= lock_nxt;
            drv_hs_r    <= drv_hs_nxt;
            drv_ls_r    <= drv_ls_nxt;
        end
    end

    // =============================================================
    // Interrupt block
    // =============================================================
    logic [EV_NUM-1:0] irq_stat;
    logic [EV_NUM-1:0] irq_mask;
    logic              irq_w;

    hbf_irq #(.W(EV_NUM)) u_irq (
        .clk       (CLK),
        .nrst      (NRST),
        .event_set (ev),
        .wr_stat   (wr_irq_stat),
        .wr_mask   (wr_irq_mask),
        .wdata     (PWDATA[EV_NUM-1:0]),
        .stat      (irq_stat),
        .mask      (irq_mask),
        .irq       (irq_w)
    );

    // =============================================================
    // Read mux and APB answer
    // =============================================================
    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        case (PADDR)
            ADDR_CTRL: begin
                rd_word[CTRL_EN_LSB +: N]  = hb_en_r;
                rd_word[CTRL_CFG_LSB +: N] = hb_cfg_r;
                rd_word[CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT]    = underload_shutdown_ctrl_r;
                rd_word[CTRL_OVERVOLTAGE_LOCKOUT_CTRL_BIT]     = overvoltage_lockout_ctrl_r;
            end
            ADDR_STATUS: begin
                rd_word[ST_TW_BIT]         = tw_flag_r;
                rd_word[ST_OCS_BIT]        = ocs_flag_r;
                rd_word[ST_ULD_BIT]        = uld_flag_r;
                rd_word[ST_TSD_BIT]        = tsd_flag_r;
                rd_word[ST_PSF_BIT]        = psf_flag_r;
                rd_word[ST_LOCK_BIT]       = lock_r;
                rd_word[ST_LOFF_LSB +: N]  = loff_r;
                rd_word[ST_DRV_LSB +: N]   = drv_hs_r | drv_ls_r;
            end
            ADDR_IRQ_STAT: rd_word[EV_NUM-1:0] = irq_stat;
            ADDR_IRQ_MASK: rd_word[EV_NUM-1:0] = irq_mask;
            ADDR_CAUSE: begin
                rd_word[CS_OC_LSB +: N]    = cause_oc_r;
                rd_word[CS_ULD_LSB +: N]   = cause_uld_r;
                rd_word[CS_TSD_LSB +: N]   = cause_tsd_r;
            end
            default: rd_word = '0;
        endcase
    end

    // Answer is ready in the first access cycle, no wait states
    always_comb begin
        pready_nxt  = PSEL && !PENABLE;
        pslverr_nxt = PSEL && !PENABLE && !mapped(PADDR);
        prdata_nxt  = (PSEL && !PENABLE && !PWRITE) ? rd_word : prdata_r;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // =============================================================
    // Outputs
    // =============================================================
    assign PRDATA  = prdata_r;
    assign PREADY  = pready_r;
    assign PSLVERR = pslverr_r;
    assign DRV_HS  = drv_hs_r;
    assign DRV_LS  = drv_ls_r;
    assign IRQ     = irq_w;
endmodule
`default_nettype wire

// [hbf_top_asserts.sv]
`default_nettype none
module hbf_top_asserts
    import hbf_pkg::*;
#(
    parameter int NUM_HB = HB_DFLT
) (
    // Clock and reset
    input wire logic              CLK,
    input wire logic              NRST,
    // Register bus
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [11:0]       PADDR,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // Fault pins
    input wire logic [NUM_HB-1:0] OC_DET,
    input wire logic [NUM_HB-1:0] TSD_DET,
    input wire logic [NUM_HB-1:0] TW_DET,
    input wire logic              UV_DET,
    input wire logic              EN_PIN,
    // Gate commands
    input wire logic [NUM_HB-1:0] DRV_HS,
    input wire logic [NUM_HB-1:0] DRV_LS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    // =========================================================
    // Properties
    // =========================================================
    sequence s_rd(logic [11:0] a);
        PSEL && PENABLE && !PWRITE && PADDR == a;
    endsequence
    property p_oc_off;
        OC_DET[0] [*3] |=> !DRV_HS[0] && !DRV_LS[0];
    endproperty
    property p_tsd_off;
        TSD_DET[0] [*3] |=> !DRV_HS[0] && !DRV_LS[0];
    endproperty
    property p_uv_float;
        UV_DET [*3] |=> (DRV_HS | DRV_LS) == '0;
    endproperty
    property p_en_float;
        (!EN_PIN) [*3] |=> ((DRV_HS | DRV_LS) == '0) [*2];
    endproperty
    property p_psf_bit;
        UV_DET [*6] ##0 s_rd(ADDR_STATUS) |-> PRDATA[ST_PSF_BIT];
    endproperty
    property p_tw_bit;
        TW_DET[0] [*6] ##0 s_rd(ADDR_STATUS) |-> PRDATA[ST_TW_BIT];
    endproperty
    property p_loff_cfg;
        (OC_DET[0] && EN_PIN) [*8] ##0 s_rd(ADDR_CTRL)
            |-> !PRDATA[CTRL_EN_LSB] && !PRDATA[CTRL_CFG_LSB];
    endproperty
    property p_pready;
        PSEL && !PENABLE |=> PREADY && !(PSLVERR && PWRITE && PADDR == ADDR_CTRL) ##1 !PREADY;
    endproperty

    a_oc_off: assert property (p_oc_off)
        else $error("over-current bridge still driven");
    a_tsd_off: assert property (p_tsd_off)
        else $error("hot bridge still driven");
    a_uv_float: assert property (p_uv_float)
        else $error("outputs driven during under-voltage");
    a_en_float: assert property (p_en_float)
        else $error("outputs driven with enable pin low");
    a_psf_bit: assert property (p_psf_bit)
        else $error("supply fail flag missing");
    a_tw_bit: assert property (p_tw_bit)
        else $error("thermal warning flag missing");
    a_loff_cfg: assert property (p_loff_cfg)
        else $error("latched bridge keeps enable or config");
    a_pready: assert property (p_pready)
        else $error("bus answer out of step");

    c_oc: cover property (OC_DET[0] [*3]);
    c_uv: cover property (UV_DET [*3]);
    c_err: cover property (PSLVERR && PREADY);
endmodule

bind hbf_top hbf_top_asserts #(.NUM_HB(NUM_HB)) chk_u (
    .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OC_DET(OC_DET), .TSD_DET(TSD_DET), .TW_DET(TW_DET), .UV_DET(UV_DET),
    .EN_PIN(EN_PIN), .DRV_HS(DRV_HS), .DRV_LS(DRV_LS)
);
`default_nettype wire

// [hbf_top_tb.sv]
`default_nettype none
module hbf_top_tb
    import hbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          N   = 6;
    localparam logic [32:0] ALL = 33'h1_ffff_ffff;
    logic              clk, nrst, psel, penable, pwrite, pready, pslverr, irq, en_pin, ov, uv;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, ctrl_v;
    logic [N-1:0]      oc, underload_flag, tsd, tw, hs, ls;
    logic [65:0]       note_v;
    logic [65:0]       exp_q[$];
    int                bad_count = 0;
    int                samples_checked = 0;
    int                seed = 49;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    hbf_top #(.NUM_HB(N)) dut_u (
        .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OC_DET(oc), .ULD_DET(underload_flag), .TSD_DET(tsd), .TW_DET(tw),
        .OV_DET(ov), .UV_DET(uv), .EN_PIN(en_pin), .DRV_HS(hs), .DRV_LS(ls), .IRQ(irq)
    );
    hbf_host host_u (
        .clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata)
    );

    // =========================================================
    // Checking and helpers
    // =========================================================
    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    always @(posedge clk) begin
        if (psel === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            note_v = exp_q.pop_front();
            chk("read", note_v[32:0], {pslverr, prdata} & note_v[65:33]);
        end
    end

    task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back({m, e & m});
        host_u.apb(a, 1'b0, 32'h0000_0000);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        host_u.apb(a, 1'b1, d);
    endtask
    task settle;
        repeat (6) @(posedge clk);
    endtask
    task wctrl(input logic [31:0] c);
        ctrl_v = c & 32'h0003_3f3f;
        wr(ADDR_CTRL, c);
        settle();
    endtask
    // Expected gates follow enable and config unless locked out
    task drv(input logic lock);
        chk("drive", lock ? 33'h0 : 33'({ctrl_v[5:0] & ctrl_v[13:8],
            ctrl_v[5:0] & ~ctrl_v[13:8]}), 33'({hs, ls}));
    endtask
    task give_verdict;
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    // =========================================================
    // Scenarios
    // =========================================================
    initial begin
        nrst = 1'b0;
        {oc, underload_flag, tsd, tw} = '0;
        {ov, uv, en_pin} = 3'h1;
        ctrl_v = 32'h0000_0000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_CTRL, 33'h0, ALL);
        rd(ADDR_IRQ_MASK, 33'h0, ALL);
        rd(12'h0f0, 33'h1_0000_0000, ALL);
        for (int i = 0; i < 4; i++) begin
            wctrl($random(seed));
            rd(ADDR_CTRL, 33'(ctrl_v), ALL);
            drv(1'b0);
        end
        wctrl(32'h0000_153f);
        oc[0] <= 1'b1;
        settle();
        ctrl_v[0] = 1'b0;
        ctrl_v[8] = 1'b0;
        rd(ADDR_CTRL, 33'(ctrl_v), ALL);
        oc[0] <= 1'b0;
        settle();
        drv(1'b0);
        rd(ADDR_STATUS, 33'h1_0002, 33'h3f_0002);
        rd(ADDR_IRQ_STAT, 33'h2, 33'h2);
        rd(ADDR_CAUSE, 33'h1, 33'h3f);
        chk("irq", 33'h0, 33'(irq));
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        settle();
        chk("irq", 33'h1, 33'(irq));
        wr(ADDR_IRQ_STAT, 32'h0000_0002);
        settle();
        chk("irq", 33'h0, 33'(irq));
        host_u.rearm(32'h0001_153f);
        ctrl_v = 32'h0001_153f;
        settle();
        drv(1'b0);
        rd(ADDR_STATUS, 33'h0, 33'h2);
        underload_flag[1] <= 1'b1;
        settle();
        underload_flag[1] <= 1'b0;
        settle();
        ctrl_v[1] = 1'b0;
        ctrl_v[9] = 1'b0;
        drv(1'b0);
        rd(ADDR_STATUS, 33'h4, 33'h4);
        host_u.rearm(32'h0000_153f);
        ctrl_v = 32'h0000_153f;
        settle();
        rd(ADDR_STATUS, 33'h0, 33'h4);
        underload_flag[2] <= 1'b1;
        settle();
        underload_flag[2] <= 1'b0;
        settle();
        drv(1'b0);
        rd(ADDR_STATUS, 33'h4, 33'h4);
        tw[0] <= 1'b1;
        settle();
        drv(1'b0);
        rd(ADDR_STATUS, 33'h1, 33'h1);
        tw[0] <= 1'b0;
        settle();
        rd(ADDR_STATUS, 33'h0, 33'h1);
        tsd[0] <= 1'b1;
        settle();
        ctrl_v[0] = 1'b0;
        ctrl_v[8] = 1'b0;
        drv(1'b0);
        wctrl(32'h8000_0000 | ctrl_v);
        rd(ADDR_STATUS, 33'h8, 33'h8);
        tsd[0] <= 1'b0;
        settle();
        wctrl(32'h8000_0000 | ctrl_v);
        rd(ADDR_STATUS, 33'h0, 33'hc);
        ov <= 1'b1;
        settle();
        drv(1'b0);
        rd(ADDR_STATUS, 33'h4000, 33'h4000);
        wctrl(ctrl_v | 32'h0002_0000);
        drv(1'b1);
        ov <= 1'b0;
        settle();
        drv(1'b0);
        rd(ADDR_STATUS, 33'h0, 33'h4000);
        uv <= 1'b1;
        settle();
        drv(1'b1);
        rd(ADDR_STATUS, 33'h4000, 33'h4000);
        uv <= 1'b0;
        settle();
        drv(1'b0);
        oc[5] <= 1'b1;
        settle();
        oc[5] <= 1'b0;
        en_pin <= 1'b0;
        settle();
        drv(1'b1);
        en_pin <= 1'b1;
        settle();
        ctrl_v[5] = 1'b0;
        ctrl_v[13] = 1'b0;
        drv(1'b0);
        rd(ADDR_STATUS, 33'h0, 33'h2);
        @(posedge clk);
        chk("queue", 33'h0, 33'(exp_q.size()));
        give_verdict();
    end
endmodule
`default_nettype wire
